// *** vector_base_and_reset_control.sv ***
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module vector_base_and_reset_control
  import vtrc_pkg::*;
#(
  parameter logic BIG_ENDIAN = 1'b0
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [PRI_BITS-1:0] active_priority_in,
  input wire logic [PRI_BITS-1:0] pending_priority_in,
  output logic [31:0] rdata_out,
  output logic [31:0] table_base_out,
  output logic table_in_sram_out,
  output logic [2:0] priority_grouping_out,
  output logic system_reset_request_out,
  output logic [PRI_BITS-1:0] group_mask_out,
  output logic preempt_out
);

  logic [31:0] vector_table_base;
  logic [2:0] priority_grouping;
  logic system_reset_request;
  logic key_ok;
  logic [31:0] next_rdata;

  // Mask of group-priority bits for a grouping value
  function automatic logic [PRI_BITS-1:0] group_mask(input logic [2:0] grp);
    logic [PRI_BITS-1:0] m;
    m = '1;
    for (int i = 0; i < PRI_BITS; i++) begin
      if (i <= int'(grp)) begin
        m[i] = 1'b0;
      end
    end
    return m;
  endfunction : group_mask

  // Priority bits the implementation lacks are forced low
  function automatic logic [PRI_BITS-1:0] impl_pri(input logic [PRI_BITS-1:0] p);
    logic [PRI_BITS-1:0] m;
    m = '0;
    for (int i = PRI_BITS - IMPL_PRI_BITS; i < PRI_BITS; i++) begin
      m[i] = 1'b1;
    end
    return p & m;
  endfunction : impl_pri

  assign key_ok = (wdata_in[KEY_LSB +: 16] == WRITE_KEY);

  // Strobe decodes shared by the checks below
  logic base_write;
  logic ctrl_write;
  logic keyed_write;
  logic reset_write;
  logic base_read;
  logic ctrl_read;
  logic other_read;

  assign base_write = wr_in && (addr_in == VECTOR_TABLE_BASE_ADDR);
  assign ctrl_write = wr_in && (addr_in == KEYED_CONTROL_ADDR);
  assign keyed_write = ctrl_write && key_ok;
  assign reset_write = keyed_write && wdata_in[RESET_REQ_BIT];
  assign base_read = rd_in && (addr_in == VECTOR_TABLE_BASE_ADDR);
  assign ctrl_read = rd_in && (addr_in == KEYED_CONTROL_ADDR);
  assign other_read = rd_in && !base_read && !ctrl_read;

  // Implemented priority bits, built once as a reference for the checks
  logic [PRI_BITS-1:0] impl_mask;
  for (genvar b = 0; b < PRI_BITS; b++) begin : g_impl_mask
    assign impl_mask[b] = (b >= PRI_BITS - IMPL_PRI_BITS);
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vector_table_base <= VECTOR_TABLE_BASE_RESET;
    end else if (wr_in && addr_in == VECTOR_TABLE_BASE_ADDR) begin
      vector_table_base <= wdata_in & TABLE_OFFSET_STORE_MASK;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      priority_grouping <= GROUPING_RESET;
    end else if (wr_in && addr_in == KEYED_CONTROL_ADDR && key_ok) begin
      priority_grouping <= wdata_in[GROUPING_LSB +: 3];
    end
  end

  // Sticky until the system reset clears it; one write suffices
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      system_reset_request <= 1'b0;
    end else if (wr_in && addr_in == KEYED_CONTROL_ADDR && key_ok
                 && wdata_in[RESET_REQ_BIT]) begin
      system_reset_request <= 1'b1;
    end
  end

  always_comb begin
    next_rdata = UNMAPPED_READ;
    if (addr_in == VECTOR_TABLE_BASE_ADDR) begin
      next_rdata = vector_table_base & TABLE_OFFSET_MASK;
    end else if (addr_in == KEYED_CONTROL_ADDR) begin
      next_rdata[KEY_LSB +: 16] = KEY_READBACK;
      next_rdata[ENDIAN_BIT] = BIG_ENDIAN;
      next_rdata[GROUPING_LSB +: 3] = priority_grouping;
      // Reset request and debug bits 2..0 stay zero on read
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= '0;
    end
  end

  assign table_base_out = vector_table_base & TABLE_OFFSET_MASK;
  assign table_in_sram_out = vector_table_base[TABLE_REGION_BIT];
  assign priority_grouping_out = priority_grouping;
  assign system_reset_request_out = system_reset_request;
  assign group_mask_out = group_mask(priority_grouping);
  // Lower value is higher priority; equal groups never preempt
  assign preempt_out = (impl_pri(pending_priority_in) & group_mask_out)
                     < (impl_pri(active_priority_in) & group_mask_out);

  vector_table_base_low_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    table_base_out[6:0] == 7'h00)
    else $error("Vector base low bits not zero");

  vector_table_base_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_in && addr_in == VECTOR_TABLE_BASE_ADDR |=>
      table_base_out == ($past(wdata_in) & TABLE_OFFSET_STORE_MASK))
    else $error("Vector base not stored");

  region_sel_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    table_in_sram_out == table_base_out[TABLE_REGION_BIT])
    else $error("Region select mismatch");

  key_reject_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_in && addr_in == KEYED_CONTROL_ADDR && !key_ok |=>
      $stable(priority_grouping_out) && $stable(system_reset_request_out))
    else $error("Unkeyed write took effect");

  key_read_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    rd_in && addr_in == KEYED_CONTROL_ADDR |=>
      rdata_out[31:16] == KEY_READBACK && rdata_out[ENDIAN_BIT] == BIG_ENDIAN
      && rdata_out[2:0] == 3'h0)
    else $error("Control readback wrong");

  grouping_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_in && addr_in == KEYED_CONTROL_ADDR && key_ok |=>
      priority_grouping_out == $past(wdata_in[GROUPING_LSB +: 3]))
    else $error("Grouping not written");

  reset_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_in && addr_in == KEYED_CONTROL_ADDR && key_ok && wdata_in[RESET_REQ_BIT] |=>
      system_reset_request_out [*8])
    else $error("Reset request not held");

  split_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    priority_grouping_out == 3'h7 |-> group_mask_out == 8'h00 && !preempt_out)
    else $error("Grouping seven not all sub");

  group_only_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ((pending_priority_in & group_mask_out) == (active_priority_in & group_mask_out))
      |-> !preempt_out)
    else $error("Subpriority caused preemption");

  base_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !base_write |=> $stable(table_base_out))
    else $error("Vector base changed without write");

  base_top_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    table_base_out[31:30] == 2'h0)
    else $error("Vector base top bits not zero");

  ctrl_no_base_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ctrl_write |=> $stable(table_base_out))
    else $error("Control write moved vector base");

  grp_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !keyed_write |=> $stable(priority_grouping_out))
    else $error("Grouping changed without keyed write");

  base_no_ctrl_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    base_write |=> $stable(priority_grouping_out) && $stable(system_reset_request_out))
    else $error("Vector base write touched control");

  req_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    system_reset_request_out |=> system_reset_request_out)
    else $error("Reset request dropped before reset");

  req_cause_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !system_reset_request_out && !reset_write |=> !system_reset_request_out)
    else $error("Reset request without keyed write");

  req_set_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    reset_write |=> system_reset_request_out)
    else $error("Reset request not raised");

  bad_key_req_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ctrl_write && !key_ok && !system_reset_request_out |=> !system_reset_request_out)
    else $error("Unkeyed write raised reset request");

  idle_read_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !rd_in |=> rdata_out == 32'h0000_0000)
    else $error("Read data outside read cycle");

  base_read_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    base_read |=> rdata_out == $past(table_base_out))
    else $error("Vector base readback wrong");

  base_read_low_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    base_read |=> rdata_out[6:0] == 7'h00)
    else $error("Vector base low bits read nonzero");

  base_read_region_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    base_read |=> rdata_out[TABLE_REGION_BIT] == $past(table_in_sram_out))
    else $error("Region bit readback wrong");

  ctrl_reserved_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ctrl_read |=> rdata_out[14:11] == 4'h0 && rdata_out[7:3] == 5'h00)
    else $error("Control reserved bits read nonzero");

  ctrl_grp_read_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ctrl_read |=> rdata_out[GROUPING_LSB +: 3] == $past(priority_grouping_out))
    else $error("Grouping readback wrong");

  req_read_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ctrl_read && system_reset_request_out |=> !rdata_out[RESET_REQ_BIT])
    else $error("Reset request bit read nonzero");

  other_read_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    other_read |=> rdata_out == 32'h0000_0000)
    else $error("Unmapped read nonzero");

  region_follow_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    base_write |=> table_in_sram_out == $past(wdata_in[TABLE_REGION_BIT]))
    else $error("Region select not taken from write");

  mask_top_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    priority_grouping_out != 3'h7 |-> group_mask_out[PRI_BITS-1])
    else $error("Top priority bit not in group");

  mask_low_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    group_mask_out[0] == 1'b0)
    else $error("Lowest priority bit not sub");

  mask_shape_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    group_mask_out == 8'(8'hff << (int'(priority_grouping_out) + 1)))
    else $error("Group mask shape wrong");

  mask_stable_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $stable(priority_grouping_out) |-> $stable(group_mask_out))
    else $error("Group mask moved on its own");

  impl_bits_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    impl_pri(active_priority_in) == (active_priority_in & impl_mask))
    else $error("Missing priority bits not zero");

  equal_no_preempt_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    active_priority_in == pending_priority_in |-> !preempt_out)
    else $error("Equal priority preempted");

  preempt_differs_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    preempt_out |->
      (pending_priority_in & group_mask_out) != (active_priority_in & group_mask_out))
    else $error("Preemption with equal groups");

  top_bit_win_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    priority_grouping_out != 3'h7 && !pending_priority_in[PRI_BITS-1]
      && active_priority_in[PRI_BITS-1] |-> preempt_out)
    else $error("Higher group did not preempt");

endmodule : vector_base_and_reset_control

// *** vtrc_pkg.sv ***
package vtrc_pkg;
  localparam logic [7:0] VECTOR_TABLE_BASE_ADDR = 8'h08;
  localparam logic [7:0] KEYED_CONTROL_ADDR = 8'h0c;
  localparam logic [31:0] VECTOR_TABLE_BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] TABLE_OFFSET_MASK = 32'hffff_ff80;
  localparam logic [31:0] TABLE_OFFSET_STORE_MASK = 32'h3fff_ff80;
  localparam int TABLE_REGION_BIT = 29;
  localparam logic [15:0] WRITE_KEY = 16'h05fa;
  localparam logic [15:0] KEY_READBACK = 16'hfa05;
  localparam int KEY_LSB = 16;
  localparam int ENDIAN_BIT = 15;
  localparam int GROUPING_LSB = 8;
  localparam logic [2:0] GROUPING_RESET = 3'h0;
  localparam int RESET_REQ_BIT = 2;
  localparam int PRI_BITS = 8;
  localparam int IMPL_PRI_BITS = 8;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : vtrc_pkg

// *** sys_reset_model.sv ***
`timescale 1ns/1ps
module sys_reset_model (
  input wire logic clk_sys_in,
  input wire logic req_in,
  output logic rst_b_out = 1'b1
);
  logic [2:0] cnt = 3'h0;
  // Slow on purpose, so the request must hold on its own for eight cycles
  always @(posedge clk_sys_in) begin
    cnt <= req_in ? cnt + 3'h1 : 3'h0;
    rst_b_out <= !(req_in && cnt == 3'h7);
  end
endmodule : sys_reset_model

// *** vector_base_and_reset_control_tb_top.sv ***
`timescale 1ns/1ps
module vector_base_and_reset_control_tb_top;
  import vtrc_pkg::*;
  logic clk_sys_in = 1'b0, por_b = 1'b0, wr_in = 1'b0, rd_in = 1'b0, sys_rst_b;
  logic sram_out, req_out, pre_out;
  logic [2:0] grp_out;
  logic [7:0] addr_in = 8'h00, act = 8'h00, pend = 8'h00, m, mask_out;
  logic [31:0] wdata_in = 32'h0, rdata_out, base_out;
  logic [19:0] rows [10];
  int n_mismatch = 0, num_checks = 0;
  wire logic rst_b_in = por_b & sys_rst_b;
  always #12.5 clk_sys_in = ~clk_sys_in;
  vector_base_and_reset_control #(.BIG_ENDIAN(1'b0)) u_dut (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .active_priority_in(act), .pending_priority_in(pend), .rdata_out(rdata_out),
    .table_base_out(base_out), .table_in_sram_out(sram_out), .priority_grouping_out(grp_out),
    .system_reset_request_out(req_out), .group_mask_out(mask_out), .preempt_out(pre_out));
  sys_reset_model u_sys (.clk_sys_in(clk_sys_in), .req_in(req_out), .rst_b_out(sys_rst_b));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    // Grouping, active, pending, expected preemption
    rows = '{{3'h0, 8'h04, 8'h03, 1'b1}, {3'h0, 8'h05, 8'h04, 1'b0}, {3'h1, 8'h04, 8'h03, 1'b1},
      {3'h2, 8'h08, 8'h07, 1'b1}, {3'h2, 8'h07, 8'h00, 1'b0}, {3'h3, 8'h1f, 8'h10, 1'b0},
      {3'h4, 8'h20, 8'h1f, 1'b1}, {3'h5, 8'h40, 8'h3f, 1'b1}, {3'h6, 8'h80, 8'h7f, 1'b1},
      {3'h7, 8'hff, 8'h00, 1'b0}};
    repeat (12) @(posedge clk_sys_in);
    por_b <= 1'b1;
    @(posedge clk_sys_in);
    #1 chk(mask_out, 32'hfe);
    rd(KEYED_CONTROL_ADDR, 32'hfa05_0000);
    rd(VECTOR_TABLE_BASE_ADDR, 32'h0);
    foreach (rows[i]) begin
      act <= rows[i][16:9];
      pend <= rows[i][8:1];
      wr(KEYED_CONTROL_ADDR, {16'h05fa, 5'h0, rows[i][19:17], 8'h00});
      m = 8'hff << ({1'b0, rows[i][19:17]} + 4'h1);
      chk(grp_out, rows[i][19:17]);
      chk(mask_out, m);
      chk(pre_out, rows[i][0]);
      rd(KEYED_CONTROL_ADDR, {16'hfa05, 5'h0, rows[i][19:17], 8'h00});
    end
    wr(VECTOR_TABLE_BASE_ADDR, 32'hffff_ffff);
    rd(VECTOR_TABLE_BASE_ADDR, 32'h3fff_ff80);
    chk(sram_out, 1'b1);
    wr(VECTOR_TABLE_BASE_ADDR, 32'h0000_0200);
    chk(base_out, 32'h200);
    chk(sram_out, 1'b0);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0);
    @(posedge clk_sys_in);
    #1 chk(rdata_out, 32'h0);
    // Wrong key: grouping and reset request must both stay put
    wr(KEYED_CONTROL_ADDR, 32'h05fb_0304);
    chk(req_out, 1'b0);
    chk(grp_out, 3'h7);
    wr(KEYED_CONTROL_ADDR, 32'h05fa_0504);
    chk(req_out, 1'b1);
    rd(KEYED_CONTROL_ADDR, 32'hfa05_0500);
    wr(KEYED_CONTROL_ADDR, 32'h05fa_0500);
    chk(req_out, 1'b1);
    for (int i = 0; i < 20 && rst_b_in; i++) begin
      @(posedge clk_sys_in);
      #1;
    end
    chk(rst_b_in, 1'b0);
    if (!rst_b_in) begin
      @(posedge clk_sys_in);
      #1 chk(req_out, 1'b0);
      chk(grp_out, 3'h0);
    end
    end_of_test();
  end
endmodule : vector_base_and_reset_control_tb_top
